//--- core/eira_params.svh
// Constants for the nonvolatile store access registers and the CPU-side command registers.
`ifndef EIRA_PARAMS_SVH
`define EIRA_PARAMS_SVH

// Data-space addresses of the device registers.
`define EIRA_ADDR_EVENT 8'h3E
`define EIRA_ADDR_CTRL 8'h3F
`define EIRA_ADDR_DATA 8'h40
`define EIRA_ADDR_LOW 8'h41
`define EIRA_ADDR_HIGH 8'h42
`define EIRA_ADDR_TEMP 8'h84

// Short I/O address rules.
`define EIRA_IO_OFFSET 8'h20
`define EIRA_IO_TOP 8'h3F
`define EIRA_IO_BIT_TOP 8'h1F

// Control register fields.
`define EIRA_CTRL_READ 0
`define EIRA_CTRL_STROBE 1
`define EIRA_CTRL_ARM 2
`define EIRA_CTRL_IE 3
`define EIRA_CTRL_MODE_LO 4
`define EIRA_CTRL_MODE_HI 5

// Event register fields, write one to clear.
`define EIRA_EV_WRITE_DONE 0
`define EIRA_EV_READ_DONE 1
`define EIRA_EV_COUNT 2

// Programming modes.
`define EIRA_MODE_ATOMIC 2'b00
`define EIRA_MODE_ERASE 2'b01
`define EIRA_MODE_PROGRAM 2'b10
`define EIRA_MODE_RESERVED 2'b11

// Store geometry and reset values.
`define EIRA_DEPTH 1024
`define EIRA_ERASED 8'hFF
`define EIRA_RESET_BYTE 8'h00
`define EIRA_RESET_MODE 2'b00

// Timing.
`define EIRA_CLK_MHZ 100
`define EIRA_T_ATOMIC_US 3400
`define EIRA_T_SPLIT_US 1800
`define EIRA_PROG_CNT_W 19
`define EIRA_ARM_CYCLES 3'd4

// CPU-side command registers on APB.
`define EIRA_APB_CMD 8'h00
`define EIRA_APB_STATUS 8'h04
`define EIRA_CMD_DATA_LO 0
`define EIRA_CMD_ADDR_LO 8
`define EIRA_CMD_BIT_LO 16
`define EIRA_CMD_OP_LO 20
`define EIRA_STAT_BUSY 0
`define EIRA_STAT_REFUSED 1
`define EIRA_STAT_SKIP 2
`define EIRA_STAT_RDATA_LO 8

`endif

//--- core/eira_pkg.sv
// Types shared by both ends of the CPU access port.
package eira_pkg;

  typedef enum logic [2:0]
  {
    data_space_load,
    data_space_write,
    io_read,
    io_write,
    io_bit_set,
    io_bit_clear,
    skip_if_io_bit_high,
    skip_if_io_bit_low
  } eira_op_e;

endpackage

//--- core/eira_if.sv
// CPU access port joining the CPU-side end and the device end.
interface eira_if;
  import eira_pkg::*;

  logic req;
  eira_op_e op;
  logic [7:0] addr;
  logic [2:0] bit_sel;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic skip;
  logic refused;

  modport cpu
  (
    output req,
    output op,
    output addr,
    output bit_sel,
    output wdata,
    input ack,
    input rdata,
    input skip,
    input refused
  );

  modport dev
  (
    input req,
    input op,
    input addr,
    input bit_sel,
    input wdata,
    output ack,
    output rdata,
    output skip,
    output refused
  );
endinterface

//--- core/eira_store.sv
// Byte-wide nonvolatile cell array with erase and program actions.
`include "eira_params.svh"

module eira_store
(
  // Clock
  input wire logic core_clk,
  // Read port
  input wire logic [9:0] rd_addr,
  output logic [7:0] rd_data,
  // Program port
  input wire logic wr_en,
  input wire logic [1:0] wr_mode,
  input wire logic [9:0] wr_addr,
  input wire logic [7:0] wr_data
);
  logic [7:0] cells [0:`EIRA_DEPTH-1];
  logic [7:0] next_cell;

  assign rd_data = cells[rd_addr];

  // Program alone can only clear bits, so it lands on top of the old value.
  assign next_cell = (wr_mode == `EIRA_MODE_ERASE) ? `EIRA_ERASED :
                     (wr_mode == `EIRA_MODE_PROGRAM) ? (cells[wr_addr] & wr_data) : wr_data;

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      cells[wr_addr] <= next_cell;
    end
  end
endmodule

//--- core/eira_device.sv
// Device end: I/O address decoder and the nonvolatile store access registers.
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
//
// Implementation choice: the CPU access port to the registers.
`include "eira_params.svh"

module eira_device
#(
  parameter int unsigned ATOMIC_CYCLES = `EIRA_T_ATOMIC_US * `EIRA_CLK_MHZ,
  parameter int unsigned SPLIT_CYCLES = `EIRA_T_SPLIT_US * `EIRA_CLK_MHZ
)
(
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic por,
  // CPU access port
  eira_if.dev cpu,
  // Status
  output logic nv_busy
);
  import eira_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [1:0] nv_program_mode;
  logic nv_ready_ie;
  logic [2:0] arm_cnt;
  logic nv_write_arm;
  logic [9:0] nv_address;
  logic [7:0] nv_data;
  logic [7:0] temp_byte;
  logic [`EIRA_EV_COUNT-1:0] event_flags;
  logic [`EIRA_PROG_CNT_W-1:0] prog_cnt;
  logic [7:0] prog_data;
  logic [1:0] prog_mode;
  logic [7:0] store_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Access decode.

  logic is_bitop;
  logic is_skip;
  logic is_io;
  logic refused;
  logic [7:0] daddr;
  logic fire_any;
  logic fire;
  logic is_wr;
  logic is_rd;
  logic [7:0] wmask;
  logic [7:0] wval;

  assign is_bitop = (cpu.op == io_bit_set) || (cpu.op == io_bit_clear);
  assign is_skip = (cpu.op == skip_if_io_bit_high) || (cpu.op == skip_if_io_bit_low);
  assign is_io = is_bitop || is_skip || (cpu.op == io_read) || (cpu.op == io_write);

  assign refused = (is_io && (cpu.addr > `EIRA_IO_TOP)) || ((is_bitop || is_skip) && (cpu.addr > `EIRA_IO_BIT_TOP));

  assign daddr = is_io ? (cpu.addr + `EIRA_IO_OFFSET) : cpu.addr;

  assign fire_any = cpu.req && !cpu.ack;
  assign fire = fire_any && !refused;
  assign is_wr = fire && ((cpu.op == data_space_write) || (cpu.op == io_write) || is_bitop);
  assign is_rd = fire && ((cpu.op == data_space_load) || (cpu.op == io_read) || is_skip);

  // Bit operations write through a one-bit mask
  assign wmask = is_bitop ? (8'h01 << cpu.bit_sel) : 8'hFF;
  assign wval = (cpu.op == io_bit_set) ? 8'hFF : (cpu.op == io_bit_clear) ? 8'h00 : cpu.wdata;

  logic wr_ctrl;
  logic wr_event;
  logic wr_data;
  logic wr_low;
  logic wr_high;
  logic wr_temp;
  logic rd_low;

  assign wr_ctrl = is_wr && (daddr == `EIRA_ADDR_CTRL);
  assign wr_event = is_wr && (daddr == `EIRA_ADDR_EVENT);
  assign wr_data = is_wr && (daddr == `EIRA_ADDR_DATA);
  assign wr_low = is_wr && (daddr == `EIRA_ADDR_LOW);
  assign wr_high = is_wr && (daddr == `EIRA_ADDR_HIGH);
  assign wr_temp = is_wr && (daddr == `EIRA_ADDR_TEMP);
  assign rd_low = is_rd && (daddr == `EIRA_ADDR_LOW);

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer. Unmapped and reserved locations read as zero.

  logic [7:0] ctrl_val;
  logic [7:0] rd_val;

  assign ctrl_val = {2'b00, nv_program_mode, nv_ready_ie, nv_write_arm, nv_busy, 1'b0};
  assign rd_val = (daddr == `EIRA_ADDR_CTRL) ? ctrl_val :
                  (daddr == `EIRA_ADDR_EVENT) ? {6'b00_0000, event_flags} :
                  (daddr == `EIRA_ADDR_DATA) ? nv_data :
                  (daddr == `EIRA_ADDR_LOW) ? nv_address[7:0] :
                  (daddr == `EIRA_ADDR_HIGH) ? temp_byte :
                  (daddr == `EIRA_ADDR_TEMP) ? temp_byte : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Control actions.

  logic [1:0] next_mode;
  logic start_req;
  logic start_ok;
  logic read_go;
  logic prog_done;
  logic [`EIRA_PROG_CNT_W-1:0] prog_len;

  // Mode field frozen while the strobe is set
  assign next_mode[0] = (wr_ctrl && wmask[`EIRA_CTRL_MODE_LO] && !nv_busy) ?
                        wval[`EIRA_CTRL_MODE_LO] : nv_program_mode[0];
  assign next_mode[1] = (wr_ctrl && wmask[`EIRA_CTRL_MODE_HI] && !nv_busy) ?
                        wval[`EIRA_CTRL_MODE_HI] : nv_program_mode[1];

  assign start_req = wr_ctrl && wmask[`EIRA_CTRL_STROBE] && wval[`EIRA_CTRL_STROBE] && nv_write_arm && !nv_busy;

  assign start_ok = start_req && (next_mode != `EIRA_MODE_RESERVED);

  assign read_go = wr_ctrl && wmask[`EIRA_CTRL_READ] && wval[`EIRA_CTRL_READ] && !nv_busy;

  assign prog_len = (next_mode == `EIRA_MODE_ATOMIC) ? ATOMIC_CYCLES[`EIRA_PROG_CNT_W-1:0] :
                    SPLIT_CYCLES[`EIRA_PROG_CNT_W-1:0];

  assign prog_done = nv_busy && (prog_cnt == `EIRA_PROG_CNT_W'(1));
  assign nv_write_arm = (arm_cnt != 3'd0);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      arm_cnt <= 3'd0;
    else if (wr_ctrl && wmask[`EIRA_CTRL_ARM] && wval[`EIRA_CTRL_ARM])
      arm_cnt <= `EIRA_ARM_CYCLES;
    else if (arm_cnt != 3'd0)
      arm_cnt <= arm_cnt - 3'd1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      nv_ready_ie <= 1'b0;
    else if (wr_ctrl && wmask[`EIRA_CTRL_IE])
      nv_ready_ie <= wval[`EIRA_CTRL_IE];
  end

  // The mode survives a system reset while programming is under way.
  always_ff @(posedge core_clk or posedge por)
  begin
    if (por)
      nv_program_mode <= `EIRA_RESET_MODE;
    else if (rst && !nv_busy)
      nv_program_mode <= `EIRA_RESET_MODE;
    else
      nv_program_mode <= next_mode;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Programming engine. It runs on the power-on reset only, so a system reset
  // lets a started operation complete.

  always_ff @(posedge core_clk or posedge por)
  begin
    if (por)
    begin
      nv_busy <= 1'b0;
      prog_cnt <= '0;
      prog_data <= `EIRA_RESET_BYTE;
      prog_mode <= `EIRA_RESET_MODE;
    end
    else if (start_ok)
    begin
      nv_busy <= 1'b1;
      prog_cnt <= prog_len;
      prog_data <= nv_data;
      prog_mode <= next_mode;
    end
    else if (nv_busy)
    begin
      prog_cnt <= prog_cnt - `EIRA_PROG_CNT_W'(1);
      nv_busy <= !prog_done;
    end
  end

  eira_store i_eira_store
  (
    .core_clk(core_clk),
    .rd_addr(nv_address),
    .rd_data(store_rdata),
    .wr_en(prog_done),
    .wr_mode(prog_mode),
    .wr_addr(nv_address),
    .wr_data(prog_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Data, address and temporary byte.

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      nv_data <= `EIRA_RESET_BYTE;
    else if (read_go)
      nv_data <= store_rdata;
    else if (wr_data)
      nv_data <= wval;
  end

  // Unreset address, loaded on low write
  always_ff @(posedge core_clk)
  begin
    if (wr_low && !nv_busy)
      nv_address <= {temp_byte[1:0], wval};
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      temp_byte <= `EIRA_RESET_BYTE;
    else if (rd_low)
      temp_byte <= {6'b00_0000, nv_address[9:8]};
    else if (wr_high || wr_temp)
      temp_byte <= wval;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event flags: hardware set wins over a clear in the same cycle.

  logic [`EIRA_EV_COUNT-1:0] ev_set;

  assign ev_set[`EIRA_EV_WRITE_DONE] = prog_done;
  assign ev_set[`EIRA_EV_READ_DONE] = read_go;

  for (genvar i = 0; i < `EIRA_EV_COUNT; i++)
  begin : g_event
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        event_flags[i] <= 1'b0;
      else if (ev_set[i])
        event_flags[i] <= 1'b1;
      else if (wr_event && wmask[i] && wval[i])
        event_flags[i] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Answer to the CPU, one cycle after the request.

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cpu.ack <= 1'b0;
      cpu.rdata <= `EIRA_RESET_BYTE;
      cpu.skip <= 1'b0;
      cpu.refused <= 1'b0;
    end
    else
    begin
      cpu.ack <= fire_any;
      if (fire_any)
      begin
        cpu.refused <= refused;
        cpu.rdata <= is_rd ? rd_val : 8'h00;
        cpu.skip <= is_rd && is_skip && (rd_val[cpu.bit_sel] == (cpu.op == skip_if_io_bit_high));
      end
    end
  end
endmodule

//--- core/eira_host.sv
// CPU-side end: APB command registers that drive single accesses on the CPU access port.
`include "eira_params.svh"

module eira_host
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU access port
  eira_if.cpu cpu
);
  import eira_pkg::*;

  logic done_refused;
  logic done_skip;
  logic [7:0] done_rdata;
  logic sel_cmd;
  logic sel_status;
  logic take;
  logic [31:0] rd_word;

  assign sel_cmd = (paddr == `EIRA_APB_CMD);
  assign sel_status = (paddr == `EIRA_APB_STATUS);
  assign rd_word = sel_status ? {16'h0000, done_rdata, 5'b0_0000, done_skip, done_refused, cpu.req} :
                   sel_cmd ? {9'h000, cpu.op, 1'b0, cpu.bit_sel, cpu.addr, cpu.wdata} : 32'h0000_0000;

  // Software owns reserved bits and mode choice
  assign take = psel && penable && pready && pwrite && sel_cmd && !cpu.req;

  // One wait state keeps the APB answer registered.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      prdata <= rd_word;
      pslverr <= !(sel_cmd || sel_status);
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Byte order follows software command order
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cpu.req <= 1'b0;
      cpu.op <= data_space_load;
      cpu.addr <= 8'h00;
      cpu.bit_sel <= 3'h0;
      cpu.wdata <= 8'h00;
      done_refused <= 1'b0;
      done_skip <= 1'b0;
      done_rdata <= 8'h00;
    end
    else if (take)
    begin
      cpu.req <= 1'b1;
      cpu.op <= eira_op_e'(pwdata[`EIRA_CMD_OP_LO +: 3]);
      cpu.addr <= pwdata[`EIRA_CMD_ADDR_LO +: 8];
      cpu.bit_sel <= pwdata[`EIRA_CMD_BIT_LO +: 3];
      cpu.wdata <= pwdata[`EIRA_CMD_DATA_LO +: 8];
    end
    else if (cpu.req && cpu.ack)
    begin
      cpu.req <= 1'b0;
      done_refused <= cpu.refused;
      done_skip <= cpu.skip;
      done_rdata <= cpu.rdata;
    end
  end
endmodule

//--- verification/eira_checker.sv
// Concurrent checks on the CPU access port and the programming busy flag.
module eira_checker
#(
  parameter int unsigned ATOMIC_CYCLES = 340000
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Access port and status
  input wire logic req,
  input wire eira_pkg::eira_op_e op,
  input wire logic [7:0] addr,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic skip,
  input wire logic refused,
  input wire logic nv_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import eira_pkg::*;

  logic [31:0] busy_run;
  wire bit_op = op inside {io_bit_set, io_bit_clear, skip_if_io_bit_high, skip_if_io_bit_low};
  wire short_op = op inside {io_read, io_write};
  wire mem_op = op inside {data_space_load, data_space_write};

  // Counts the length of the current programming run.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      busy_run <= 32'h0000_0000;
    else if (nv_busy)
      busy_run <= busy_run + 32'h0000_0001;
    else
      busy_run <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_take;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence

  a_take_answered: assert property (s_take |=> s_answer)
    else $error("access not answered with a single ack");
  a_ack_has_cause: assert property ($rose(ack) |-> $past(req))
    else $error("ack without a request");
  a_bit_op_range: assert property (s_take ##0 bit_op |=> refused == ($past(addr) > 8'h1F))
    else $error("bit operation range decode wrong");
  a_short_io_range: assert property (s_take ##0 short_op |=> refused == ($past(addr) > 8'h3F))
    else $error("short io range decode wrong");
  a_load_store_open: assert property (s_take ##0 mem_op |=> !refused)
    else $error("load or store refused");
  a_refused_quiet: assert property (ack && refused |-> rdata == 8'h00 && !skip)
    else $error("refused access returned data");
  a_skip_only_tests: assert property (ack && skip |-> $past(op) inside {skip_if_io_bit_high, skip_if_io_bit_low})
    else $error("skip flag on a non-test access");
  a_busy_from_strobe: assert property ($rose(nv_busy) |-> ack)
    else $error("programming began without an access");
  a_busy_min_span: assert property ($rose(nv_busy) |-> nv_busy [*8])
    else $error("programming run too short");
  a_busy_bounded: assert property (busy_run <= ATOMIC_CYCLES)
    else $error("programming run too long");
endmodule

//--- verification/eeprom_io_register_access_tb.sv
// Testbench driving both ends of the nonvolatile access port over APB.
`include "eira_params.svh"

module eeprom_io_register_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eira_pkg::*;

  localparam int AT = 120;
  localparam int SP = 60;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic nv_busy;
  int fails = 0;
  int n_checks = 0;
  int busy_cyc = 0;

  eira_if bus ();
  eira_host i_eira_host (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu(bus.cpu));
  eira_device #(.ATOMIC_CYCLES(AT), .SPLIT_CYCLES(SP)) i_eira_device (.core_clk(core_clk), .rst(rst),
    .por(por), .cpu(bus.dev), .nv_busy(nv_busy));
  eira_checker #(.ATOMIC_CYCLES(AT)) i_eira_checker (.core_clk(core_clk), .rst(rst), .req(bus.req),
    .op(bus.op), .addr(bus.addr), .ack(bus.ack), .rdata(bus.rdata), .skip(bus.skip), .refused(bus.refused),
    .nv_busy(nv_busy));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    if (nv_busy === 1'b1)
      busy_cyc++;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [31:0] cw(input eira_op_e o, input logic [7:0] a, input logic [2:0] b,
    input logic [7:0] d);
    return {9'h000, o, 1'b0, b, a, d};
  endfunction

  // The request stays up until pready is seen; the caller releases it.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
  endtask

  task automatic apb_end;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic host_wait(output logic [31:0] s);
    logic e;
    do
    begin
      apb(1'b0, `EIRA_APB_STATUS, 32'h0000_0000, s, e);
    end
    while (s[0] !== 1'b0);
    apb_end;
  endtask

  task automatic dacc(input eira_op_e o, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d,
    output logic [31:0] s);
    logic e;
    apb(1'b1, `EIRA_APB_CMD, cw(o, a, b, d), s, e);
    host_wait(s);
  endtask

  // Every access is compared on its returned byte and its status flags.
  task automatic acc(input eira_op_e o, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d,
    input logic [7:0] ex, input logic [2:0] fl);
    logic [31:0] s;
    dacc(o, a, b, d, s);
    chk({s[15:8], s[2:0]}, {ex, fl});
  endtask

  task automatic pulse_rst;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
  endtask

  // Arm and strobe go back to back so the strobe lands inside the arm window.
  task automatic prog(input logic [1:0] m, input logic arm, input logic [7:0] d, input logic [7:0] ex,
    input int len, input logic mid);
    logic [31:0] s;
    logic e;
    int c0;
    acc(io_write, 8'h20, 3'd0, d, 8'h00, 3'b000);
    c0 = busy_cyc;
    apb(1'b1, `EIRA_APB_CMD, cw(data_space_write, 8'h3F, 3'd0, {2'b00, m, 1'b0, arm, 2'b00}), s, e);
    apb(1'b1, `EIRA_APB_CMD, cw(data_space_write, 8'h3F, 3'd0, {2'b00, m, 4'b0010}), s, e);
    apb_end;
    host_wait(s);
    if (mid)
      pulse_rst;
    if (len > 0)
    begin
      acc(data_space_write, 8'h3F, 3'd0, {2'b00, ~m, 4'b0000}, 8'h00, 3'b000);
      acc(data_space_write, 8'h41, 3'd0, 8'hEE, 8'h00, 3'b000);
      acc(io_bit_set, 8'h1F, 3'd0, 8'h00, 8'h00, 3'b000);
      acc(io_read, 8'h20, 3'd0, 8'h00, d, 3'b000);
      acc(data_space_load, 8'h3F, 3'd0, 8'h00, {2'b00, m, 4'b0010}, 3'b000);
    end
    do
    begin
      dacc(data_space_load, 8'h3F, 3'd0, 8'h00, s);
    end
    while (s[9] !== 1'b0);
    chk(11'(busy_cyc - c0), 11'(len));
    if (mid)
    begin
      acc(io_read, 8'h21, 3'd0, 8'h00, 8'h34, 3'b000);
      acc(data_space_load, 8'h3F, 3'd0, 8'h00, {2'b00, m, 4'b0000}, 3'b000);
      pulse_rst;
      acc(data_space_load, 8'h3F, 3'd0, 8'h00, 8'h00, 3'b000);
    end
    acc(io_bit_set, 8'h1F, 3'd0, 8'h00, 8'h00, 3'b000);
    acc(io_read, 8'h20, 3'd0, 8'h00, ex, 3'b000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] s;
    logic e;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge core_clk);
    acc(data_space_load, 8'h3F, 3'd0, 8'h00, 8'h00, 3'b000);
    acc(data_space_load, 8'h40, 3'd0, 8'h00, 8'h00, 3'b000);
    acc(data_space_load, 8'h43, 3'd0, 8'h00, 8'h00, 3'b000);
    apb(1'b0, 8'h08, 32'h0000_0000, s, e);
    apb_end;
    chk({e, 10'h000}, 11'h400);
    acc(io_write, 8'h20, 3'd0, 8'hA5, 8'h00, 3'b000);
    acc(data_space_load, 8'h40, 3'd0, 8'h00, 8'hA5, 3'b000);
    acc(data_space_write, 8'h40, 3'd0, 8'h5A, 8'h00, 3'b000);
    acc(io_read, 8'h20, 3'd0, 8'h00, 8'h5A, 3'b000);
    acc(io_read, 8'h40, 3'd0, 8'h00, 8'h00, 3'b010);
    acc(io_write, 8'h64, 3'd0, 8'h11, 8'h00, 3'b010);
    acc(data_space_write, 8'h84, 3'd0, 8'h03, 8'h00, 3'b000);
    acc(data_space_load, 8'h84, 3'd0, 8'h00, 8'h03, 3'b000);
    acc(io_write, 8'h22, 3'd0, 8'h02, 8'h00, 3'b000);
    acc(io_write, 8'h21, 3'd0, 8'h34, 8'h00, 3'b000);
    acc(data_space_write, 8'h84, 3'd0, 8'h00, 8'h00, 3'b000);
    acc(io_read, 8'h21, 3'd0, 8'h00, 8'h34, 3'b000);
    acc(data_space_load, 8'h84, 3'd0, 8'h00, 8'h02, 3'b000);
    acc(io_read, 8'h22, 3'd0, 8'h00, 8'h02, 3'b000);
    acc(io_bit_set, 8'h20, 3'd0, 8'h00, 8'h00, 3'b010);
    acc(skip_if_io_bit_high, 8'h3F, 3'd0, 8'h00, 8'h00, 3'b010);
    acc(io_bit_set, 8'h1F, 3'd3, 8'h00, 8'h00, 3'b000);
    acc(data_space_load, 8'h3F, 3'd0, 8'h00, 8'h08, 3'b000);
    acc(io_bit_clear, 8'h1F, 3'd3, 8'h00, 8'h00, 3'b000);
    acc(data_space_load, 8'h3F, 3'd0, 8'h00, 8'h00, 3'b000);
    acc(data_space_write, 8'h3F, 3'd0, 8'h04, 8'h00, 3'b000);
    acc(data_space_load, 8'h3F, 3'd0, 8'h00, 8'h00, 3'b000);
    acc(data_space_write, 8'h3F, 3'd0, 8'h02, 8'h00, 3'b000);
    acc(data_space_load, 8'h3F, 3'd0, 8'h00, 8'h00, 3'b000);
    prog(2'b00, 1'b1, 8'h5A, 8'h5A, AT, 1'b0);
    prog(2'b01, 1'b1, 8'h00, 8'hFF, SP, 1'b1);
    prog(2'b10, 1'b1, 8'h3C, 8'h3C, SP, 1'b0);
    prog(2'b11, 1'b1, 8'h00, 8'h3C, 0, 1'b0);
    prog(2'b00, 1'b0, 8'h11, 8'h3C, 0, 1'b0);
    acc(data_space_load, 8'h3E, 3'd0, 8'h00, 8'h03, 3'b000);
    acc(skip_if_io_bit_high, 8'h1E, 3'd1, 8'h00, 8'h03, 3'b100);
    acc(skip_if_io_bit_low, 8'h1E, 3'd1, 8'h00, 8'h03, 3'b000);
    acc(io_bit_set, 8'h1E, 3'd0, 8'h00, 8'h00, 3'b000);
    acc(data_space_load, 8'h3E, 3'd0, 8'h00, 8'h02, 3'b000);
    acc(data_space_write, 8'h3E, 3'd0, 8'h00, 8'h00, 3'b000);
    acc(data_space_load, 8'h3E, 3'd0, 8'h00, 8'h02, 3'b000);
    acc(data_space_write, 8'h3E, 3'd0, 8'h02, 8'h00, 3'b000);
    acc(data_space_load, 8'h3E, 3'd0, 8'h00, 8'h00, 3'b000);
    close_out;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    close_out;
  end
endmodule
